/* File: design/mbm_params.svh */
// Purpose: Constants for the Modbus slave address translator
// Assumes: Included by bare name from mbm_slave_map only
// Notes: Area entries pack base address, point count and first element index
`ifndef MBM_PARAMS_SVH
`define MBM_PARAMS_SVH

// Remap window configuration register indices
`define MBM_OFS_REMAP_KEY 16'h0f80
`define MBM_OFS_COIL_MB_START 16'h0f81
`define MBM_OFS_COIL_RELAY_START 16'h0f82
`define MBM_OFS_COIL_LENGTH 16'h0f83
`define MBM_OFS_IBIT_MB_START 16'h0f84
`define MBM_OFS_IBIT_RELAY_START 16'h0f85
`define MBM_OFS_IBIT_LENGTH 16'h0f86
`define MBM_OFS_IREG_MB_START 16'h0f87
`define MBM_OFS_IREG_INT_START 16'h0f88
`define MBM_OFS_IREG_LENGTH 16'h0f89
`define MBM_OFS_HOLD_MB_START 16'h0f8a
`define MBM_OFS_HOLD_INT_START 16'h0f8b
`define MBM_OFS_HOLD_LENGTH 16'h0f8c
`define MBM_CFG_COUNT 4'hd
`define MBM_CFG_RESET 16'h0000

// Remap key and window limits
`define MBM_REMAP_KEY 16'ha55a
`define MBM_BIT_MAX_LEN 16'h07d1
`define MBM_BIT_MAX_IDX 16'h07d1
`define MBM_REG_MAX_LEN 16'h0f00
`define MBM_REG_MAX_IDX 16'h0eff

// Function codes
`define MBM_FC_RD_COILS 8'h01
`define MBM_FC_RD_INPUTS 8'h02
`define MBM_FC_RD_HOLDING 8'h03
`define MBM_FC_RD_INPUT_REGS 8'h04
`define MBM_FC_WR_COIL 8'h05
`define MBM_FC_WR_REG 8'h06
`define MBM_FC_WR_COILS 8'h0f
`define MBM_FC_WR_REGS 8'h10

// Default bit areas {base, count, index}
`define MBM_AREA_OUT_COIL {16'h0000, 16'h0100, 16'h0000}
`define MBM_AREA_IN_BIT {16'h03e8, 16'h0100, 16'h0000}
`define MBM_AREA_RELAY_GEN {16'h07d0, 16'h0778, 16'h0000}
`define MBM_AREA_RELAY_SPEC {16'h0f48, 16'h005a, 16'h0778}
`define MBM_AREA_STEP {16'h1770, 16'h03e8, 16'h0000}
`define MBM_AREA_TMR_STAT {16'h2328, 16'h0100, 16'h0000}
`define MBM_AREA_CNT_STAT {16'h251c, 16'h0100, 16'h0000}
// Default register areas {base, count, index}
`define MBM_AREA_REG_GEN {16'h0000, 16'h0f00, 16'h0000}
`define MBM_AREA_REG_AIN {16'h0f00, 16'h0040, 16'h0f00}
`define MBM_AREA_REG_AOUT {16'h0f40, 16'h0040, 16'h0f40}
`define MBM_AREA_REG_SPEC {16'h0f80, 16'h00c8, 16'h0f80}
`define MBM_AREA_REG_EXT {16'h1388, 16'h03e7, 16'h1388}
`define MBM_AREA_DATA {16'h1770, 16'h0bb7, 16'h0000}
`define MBM_AREA_TMR_VAL {16'h2328, 16'h0100, 16'h0000}
`define MBM_AREA_CNT16_VAL {16'h251c, 16'h00c8, 16'h0000}
`define MBM_AREA_CNT32_VAL {16'h25e4, 16'h0070, 16'h00c8}
`define MBM_AREA_COUNT 5'h10
`define MBM_BIT_AREAS 5'h07

`endif

/* File: design/mbm_pkg.sv */
// Purpose: Types of the Modbus slave address translator
// Assumes: Sizes and codes are literals, nothing comes from mbm_params.svh
// Notes: State of the top module is one packed struct
package mbm_pkg;

   typedef enum logic [3:0]
   {
      KIND_NONE = 4'h0, KIND_OUT_COIL = 4'h1, KIND_IN_BIT = 4'h2,
      KIND_RELAY_GEN = 4'h3, KIND_RELAY_SPEC = 4'h4, KIND_STEP = 4'h5,
      KIND_TMR_STAT = 4'h6, KIND_CNT_STAT = 4'h7, KIND_REG_GEN = 4'h8,
      KIND_REG_AIN = 4'h9, KIND_REG_AOUT = 4'ha, KIND_REG_SPEC = 4'hb,
      KIND_EXTENDED_HOLDING_AREA = 4'hc, KIND_DATA = 4'hd,
      KIND_TMR_VAL = 4'he, KIND_CNT_VAL = 4'hf
   } mbm_kind_t;

   typedef enum logic [2:0]
   {
      CLS_NONE = 3'h0, CLS_COIL = 3'h1, CLS_IBIT = 3'h2,
      CLS_IREG = 3'h3, CLS_HOLD = 3'h4
   } mbm_class_t;

   typedef struct packed
   {
      logic [12:0][15:0] cfg;
      logic respValid;
      logic respErr;
      logic respBadFunc;
      mbm_kind_t respKind;
      logic [15:0] respIndex;
      logic respUpper;
      logic respWrite;
      logic regHit;
      logic [15:0] regRdata;
      logic remapActive;
   } mbm_state_t;

endpackage

/* File: design/mbm_win_if.sv */
// Purpose: Carries one remap window between top and window checker
// Assumes: Single clock domain, purely combinational signals
// Notes: cfg modport drives the window, chk modport answers
`timescale 1ns/1ns
`default_nettype none
interface mbm_win_if;
   logic enable;
   logic [15:0] modbusStart;
   logic [15:0] internalStart;
   logic [15:0] length;
   logic [15:0] maxLen;
   logic [15:0] maxIdx;
   logic [15:0] addr;
   logic [15:0] qty;
   logic hit;
   logic [15:0] index;

   modport cfg (output enable, modbusStart, internalStart, length, maxLen, maxIdx, addr, qty,
                input hit, index);
   modport chk (input enable, modbusStart, internalStart, length, maxLen, maxIdx, addr, qty,
                output hit, index);
endinterface
`default_nettype wire

/* File: design/mbm_window.sv */
// Purpose: Range check and translation for one remap window
// Assumes: Lengths outside 1..maxLen disable the window
// Notes: Combinational
`timescale 1ns/1ns
`default_nettype none
module mbm_window
(
   // Window
   mbm_win_if.chk win
);
   logic [17:0] offset;
   logic [17:0] lastEnd;
   logic [17:0] internalEnd;

   always_comb
   begin
      offset = {2'h0, win.addr} - {2'h0, win.modbusStart};
      lastEnd = offset + {2'h0, win.qty};
      internalEnd = {2'h0, win.internalStart} + lastEnd;
   end

   assign win.hit = win.enable && (win.addr >= win.modbusStart) && (win.qty != 16'h0000)
      && (win.length != 16'h0000) && (win.length <= win.maxLen)
      && (lastEnd <= {2'h0, win.length})
      && (internalEnd <= ({2'h0, win.maxIdx} + 18'h00001));
   assign win.index = win.internalStart + offset[15:0];
endmodule
`default_nettype wire

/* File: design/mbm_area_match.sv */
// Purpose: Hit check of a request span against one default map area
// Assumes: Span is addr .. addr+qty-1
// Notes: Combinational
`timescale 1ns/1ns
`default_nettype none
module mbm_area_match
(
   // Request span
   input wire logic [15:0] addr,
   input wire logic [15:0] qty,
   // Area
   input wire logic [15:0] base,
   input wire logic [15:0] count,
   // Result
   output logic hit,
   output logic [15:0] offset
);
   logic [16:0] diff;
   logic [16:0] spanEnd;

   always_comb
   begin
      diff = {1'b0, addr} - {1'b0, base};
      spanEnd = diff + {1'b0, qty};
      hit = (addr >= base) && (qty != 16'h0000) && (spanEnd <= {1'b0, count});
      offset = diff[15:0];
   end
endmodule
`default_nettype wire

/* File: design/mbm_slave_map.sv */
// Purpose: Modbus slave reference to internal element translator
// Assumes: Request address is the protocol address, reference minus one
// Notes: One request per cycle, answer one cycle later
//
// Function
// - A request outside the active map is answered with an error.
// - Remap mode for coil and holding codes is used only while the key register holds A55A hex.
// - Coil codes 01, 05, 15 map a coil window onto relays from a programmable start.
// - The coil window length 1 to 2001 limits access and needs the key.
// - Code 02 maps an input-bit window onto relays from a programmable start.
// - The input-bit window has length 1 to 2001 and ignores the key.
// - Code 04 maps an input-register window onto general registers 0 to 3839.
// - The input-register window has length 1 to 3840 and ignores the key.
// - Codes 03, 06, 16 map a holding window onto general registers.
// - The holding window has length 1 to 3840 and needs the key.
// - The default bit map places outputs, inputs, relays, steps, timer and counter status.
// - The default register map places general and extended registers.
// - The default map places data registers and timer current values.
// - Counters 0 to 199 give 16-bit values, 200 to 255 give 32-bit values.
// - Relay references split into general and special relays.
// - Register references split into analog input, analog output and special.
`timescale 1ns/1ns
`default_nettype none
`include "mbm_params.svh"
module mbm_slave_map
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Request
   input wire logic reqValid,
   input wire logic [7:0] reqFunc,
   input wire logic [15:0] reqAddr,
   input wire logic [15:0] reqQty,
   // Answer
   output logic respValid,
   output logic respErr,
   output logic respBadFunc,
   output mbm_pkg::mbm_kind_t respKind,
   output logic [15:0] respIndex,
   output logic respUpper,
   output logic respWrite,
   // Register file port
   input wire logic regWe,
   input wire logic [15:0] regIdx,
   input wire logic [15:0] regWdata,
   output logic regHit,
   output logic [15:0] regRdata,
   // Status
   output logic remapActive
);
   localparam logic [47:0] AREA_TABLE [16] = '{
      `MBM_AREA_OUT_COIL,
      `MBM_AREA_IN_BIT,
      `MBM_AREA_RELAY_GEN,
      `MBM_AREA_RELAY_SPEC,
      `MBM_AREA_STEP,
      `MBM_AREA_TMR_STAT,
      `MBM_AREA_CNT_STAT,
      `MBM_AREA_REG_GEN,
      `MBM_AREA_REG_AIN,
      `MBM_AREA_REG_AOUT,
      `MBM_AREA_REG_SPEC,
      `MBM_AREA_REG_EXT,
      `MBM_AREA_DATA,
      `MBM_AREA_TMR_VAL,
      `MBM_AREA_CNT16_VAL,
      `MBM_AREA_CNT32_VAL
   };
   localparam mbm_pkg::mbm_kind_t AREA_KIND [16] = '{
      mbm_pkg::KIND_OUT_COIL, mbm_pkg::KIND_IN_BIT, mbm_pkg::KIND_RELAY_GEN,
      mbm_pkg::KIND_RELAY_SPEC, mbm_pkg::KIND_STEP, mbm_pkg::KIND_TMR_STAT,
      mbm_pkg::KIND_CNT_STAT, mbm_pkg::KIND_REG_GEN, mbm_pkg::KIND_REG_AIN,
      mbm_pkg::KIND_REG_AOUT, mbm_pkg::KIND_REG_SPEC,
      mbm_pkg::KIND_EXTENDED_HOLDING_AREA, mbm_pkg::KIND_DATA,
      mbm_pkg::KIND_TMR_VAL, mbm_pkg::KIND_CNT_VAL, mbm_pkg::KIND_CNT_VAL
   };
   localparam int CNT32_AREA = 15;

   mbm_pkg::mbm_state_t cur;
   mbm_pkg::mbm_state_t next;

   mbm_pkg::mbm_class_t reqClass;
   logic reqIsWrite;
   logic reqSingle;
   logic [15:0] effQty;
   logic keyMatch;
   logic [15:0] areaOffset [16];
   logic [15:0] areaHit;
   logic [3:0] winIdx;

   // Configuration register decode
   function automatic logic cfgSelected(input logic [15:0] idx);
      cfgSelected = (idx >= `MBM_OFS_REMAP_KEY) && (idx <= `MBM_OFS_HOLD_LENGTH);
   endfunction

   function automatic logic [3:0] cfgSlot(input logic [15:0] idx);
      logic [15:0] rel;
      rel = idx - `MBM_OFS_REMAP_KEY;
      cfgSlot = rel[3:0];
   endfunction

   // Function code classification
   always_comb
   begin
      reqClass = mbm_pkg::CLS_NONE;
      reqIsWrite = 1'b0;
      reqSingle = 1'b0;
      unique case (reqFunc)
         `MBM_FC_RD_COILS: reqClass = mbm_pkg::CLS_COIL;
         `MBM_FC_WR_COIL:
         begin
            reqClass = mbm_pkg::CLS_COIL;
            reqIsWrite = 1'b1;
            reqSingle = 1'b1;
         end
         `MBM_FC_WR_COILS:
         begin
            reqClass = mbm_pkg::CLS_COIL;
            reqIsWrite = 1'b1;
         end
         `MBM_FC_RD_INPUTS: reqClass = mbm_pkg::CLS_IBIT;
         `MBM_FC_RD_INPUT_REGS: reqClass = mbm_pkg::CLS_IREG;
         `MBM_FC_RD_HOLDING: reqClass = mbm_pkg::CLS_HOLD;
         `MBM_FC_WR_REG:
         begin
            reqClass = mbm_pkg::CLS_HOLD;
            reqIsWrite = 1'b1;
            reqSingle = 1'b1;
         end
         `MBM_FC_WR_REGS:
         begin
            reqClass = mbm_pkg::CLS_HOLD;
            reqIsWrite = 1'b1;
         end
         default: reqClass = mbm_pkg::CLS_NONE;
      endcase
      effQty = reqSingle ? 16'h0001 : reqQty;
      keyMatch = (cur.cfg[0] == `MBM_REMAP_KEY);
   end

   // Remap windows: coil, input bit, input register, holding
   mbm_win_if win [4] ();

   generate
      for (genvar g = 0; g < 4; g++)
      begin : gWin
         localparam int BASE = 3 * g + 1;
         localparam logic IS_BIT = (g < 2);
         localparam logic NEEDS_KEY = (g == 0) || (g == 3);
         assign win[g].enable = NEEDS_KEY ? keyMatch : 1'b1;
         assign win[g].modbusStart = cur.cfg[BASE];
         assign win[g].internalStart = cur.cfg[BASE + 1];
         assign win[g].length = cur.cfg[BASE + 2];
         assign win[g].maxLen = IS_BIT ? `MBM_BIT_MAX_LEN : `MBM_REG_MAX_LEN;
         assign win[g].maxIdx = IS_BIT ? `MBM_BIT_MAX_IDX : `MBM_REG_MAX_IDX;
         assign win[g].addr = reqAddr;
         assign win[g].qty = effQty;
         mbm_window uWin
         (
            .win(win[g])
         );
      end
   endgenerate

   // Default map areas
   generate
      for (genvar a = 0; a < 16; a++)
      begin : gArea
         mbm_area_match uArea
         (
            .addr(reqAddr),
            .qty(effQty),
            .base(AREA_TABLE[a][47:32]),
            .count(AREA_TABLE[a][31:16]),
            .hit(areaHit[a]),
            .offset(areaOffset[a])
         );
      end
   endgenerate

   // Window hits collected for indexing
   logic [3:0] winHit;
   logic [15:0] winIndex [4];

   generate
      for (genvar h = 0; h < 4; h++)
      begin : gHit
         assign winHit[h] = win[h].hit;
         assign winIndex[h] = win[h].index;
      end
   endgenerate

   always_comb
   begin
      next = cur;
      next.respValid = 1'b0;
      next.remapActive = keyMatch;
      winIdx = 4'h0;

      // Configuration registers snoop the register file port
      if (regWe && cfgSelected(regIdx))
      begin
         next.cfg[cfgSlot(regIdx)] = regWdata;
      end
      next.regHit = cfgSelected(regIdx);
      next.regRdata = cfgSelected(regIdx) ? cur.cfg[cfgSlot(regIdx)] : 16'h0000;

      if (reqValid)
      begin
         next.respValid = 1'b1;
         next.respErr = 1'b1;
         next.respBadFunc = (reqClass == mbm_pkg::CLS_NONE);
         next.respKind = mbm_pkg::KIND_NONE;
         next.respIndex = 16'h0000;
         next.respUpper = 1'b0;
         next.respWrite = reqIsWrite;
         unique case (reqClass)
            mbm_pkg::CLS_COIL, mbm_pkg::CLS_HOLD:
            begin
               if (keyMatch)
               begin
                  winIdx = (reqClass == mbm_pkg::CLS_COIL) ? 4'h0 : 4'h3;
               end
               else
               begin
                  for (int a = 15; a >= 0; a--)
                  begin
                     if (areaHit[a] && ((a < 7) == (reqClass == mbm_pkg::CLS_COIL)))
                     begin
                        next.respErr = 1'b0;
                        next.respKind = AREA_KIND[a];
                        if (a == CNT32_AREA)
                        begin
                           next.respIndex = AREA_TABLE[a][15:0]
                              + {1'b0, areaOffset[a][15:1]};
                           next.respUpper = areaOffset[a][0];
                        end
                        else
                        begin
                           next.respIndex = AREA_TABLE[a][15:0] + areaOffset[a];
                        end
                     end
                  end
               end
            end
            mbm_pkg::CLS_IBIT: winIdx = 4'h1;
            mbm_pkg::CLS_IREG: winIdx = 4'h2;
            default: winIdx = 4'h0;
         endcase

         // Window translation when a window serves this request
         if ((reqClass == mbm_pkg::CLS_IBIT) || (reqClass == mbm_pkg::CLS_IREG)
            || (keyMatch && (reqClass != mbm_pkg::CLS_NONE)))
         begin
            if (winHit[winIdx[1:0]])
            begin
               next.respErr = 1'b0;
               next.respIndex = winIndex[winIdx[1:0]];
               if (winIdx[1])
               begin
                  next.respKind = mbm_pkg::KIND_REG_GEN;
               end
               else if (winIndex[winIdx[1:0]] >= AREA_TABLE[3][15:0])
               begin
                  next.respKind = mbm_pkg::KIND_RELAY_SPEC;
               end
               else
               begin
                  next.respKind = mbm_pkg::KIND_RELAY_GEN;
               end
            end
         end
      end

      if (!reset_n)
      begin
         next.cfg = {13{`MBM_CFG_RESET}};
         next.respValid = 1'b0;
         next.respErr = 1'b0;
         next.respBadFunc = 1'b0;
         next.respKind = mbm_pkg::KIND_NONE;
         next.respIndex = 16'h0000;
         next.respUpper = 1'b0;
         next.respWrite = 1'b0;
         next.regHit = 1'b0;
         next.regRdata = 16'h0000;
         next.remapActive = 1'b0;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      cur <= next;
   end

   assign respValid = cur.respValid;
   assign respErr = cur.respErr;
   assign respBadFunc = cur.respBadFunc;
   assign respKind = cur.respKind;
   assign respIndex = cur.respIndex;
   assign respUpper = cur.respUpper;
   assign respWrite = cur.respWrite;
   assign regHit = cur.regHit;
   assign regRdata = cur.regRdata;
   assign remapActive = cur.remapActive;
endmodule
`default_nettype wire

/* File: verif/mbm_slave_map_asserts.sv */
// Purpose: Port checks of the Modbus slave address translator
// Assumes: Bound to mbm_slave_map, answer one cycle after request
// Notes: Sees top-level ports only
`timescale 1ns/1ns
`default_nettype none
module mbm_slave_map_asserts
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Request
   input wire logic reqValid,
   input wire logic [7:0] reqFunc,
   input wire logic [15:0] reqQty,
   // Answer
   input wire logic respValid,
   input wire logic respErr,
   input wire logic respBadFunc,
   input wire mbm_pkg::mbm_kind_t respKind,
   input wire logic [15:0] respIndex,
   input wire logic respUpper,
   input wire logic respWrite,
   // Register port
   input wire logic regWe,
   input wire logic [15:0] regIdx,
   input wire logic [15:0] regWdata,
   input wire logic regHit,
   input wire logic [15:0] regRdata,
   input wire logic remapActive
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   logic goodFunc, isWrite, cfgIdx, keyWr;
   assign goodFunc = reqFunc inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0f, 8'h10};
   assign isWrite = reqFunc inside {8'h05, 8'h06, 8'h0f, 8'h10};
   assign cfgIdx = regIdx >= 16'h0f80 && regIdx <= 16'h0f8c;
   assign keyWr = regWe && regIdx == 16'h0f80;

   a_resp_next: assert property (reqValid |=> respValid)
      else $error("answer missing after request");
   a_resp_only: assert property (!reqValid |=> !respValid)
      else $error("answer without request");
   a_err_clean: assert property (respValid && respErr |->
      respKind == mbm_pkg::KIND_NONE && respIndex == 16'h0000)
      else $error("error answer carries an element");
   a_bad_func: assert property (reqValid && !goodFunc |=> respErr && respBadFunc)
      else $error("unsupported code not refused");
   a_good_func: assert property (reqValid && goodFunc |=>
      !respBadFunc && (respErr || respWrite == $past(isWrite)))
      else $error("supported code answer wrong");
   a_qty_zero: assert property (reqValid && goodFunc && !(reqFunc inside {8'h05, 8'h06})
      && reqQty == 16'h0000 |=> respErr)
      else $error("empty span accepted");
   a_key_on: assert property (keyWr && regWdata == 16'ha55a ##1 !keyWr |=> remapActive)
      else $error("remap not active after key");
   a_key_off: assert property (keyWr && regWdata != 16'ha55a ##1 !keyWr |=> !remapActive)
      else $error("remap active with wrong key");
   a_cfg_readback: assert property (regWe && cfgIdx ##1 !regWe && $stable(regIdx) |=>
      regHit && regRdata == $past(regWdata, 2))
      else $error("window register readback wrong");
   a_cfg_miss: assert property (!cfgIdx |=> !regHit && regRdata == 16'h0000)
      else $error("unmapped register answered");
   a_upper_cnt: assert property (respValid && respUpper |->
      respKind == mbm_pkg::KIND_CNT_VAL && respIndex >= 16'h00c8)
      else $error("upper word outside wide counters");

   c_err: cover property (respValid && respErr);
   c_upper: cover property (respValid && respUpper && !respErr);
   c_remap: cover property (remapActive && respValid && !respErr);
endmodule

bind mbm_slave_map mbm_slave_map_asserts u_asserts (.ref_clk, .reset_n, .reqValid, .reqFunc,
   .reqQty, .respValid, .respErr, .respBadFunc, .respKind, .respIndex, .respUpper, .respWrite,
   .regWe, .regIdx, .regWdata, .regHit, .regRdata, .remapActive);
`default_nettype wire

/* File: verif/mbm_master_model.sv */
// Purpose: Modbus master issuing decoded requests to the translator
// Assumes: Bench commands one request per go pulse
// Notes: Fields churn while idle
`timescale 1ns/1ns
`default_nettype none
module mbm_master_model
(
   // Clock
   input wire logic ref_clk,
   // Command
   input wire logic go,
   input wire logic [7:0] goFunc,
   input wire logic [15:0] goAddr,
   input wire logic [15:0] goQty,
   // Request
   output logic reqValid,
   output logic [7:0] reqFunc,
   output logic [15:0] reqAddr,
   output logic [15:0] reqQty
);
   initial
   begin
      reqValid = 1'b0;
      reqFunc = 8'h00;
      reqAddr = 16'h0000;
      reqQty = 16'h0000;
   end
   always @(posedge ref_clk)
   begin
      reqValid <= go;
      reqFunc <= go ? goFunc : ~reqFunc;
      reqAddr <= go ? goAddr : ~reqAddr;
      reqQty <= go ? goQty : ~reqQty;
   end
endmodule
`default_nettype wire

/* File: verif/mbm_slave_map_test.sv */
// Purpose: Self-checking bench of the address translator
// Assumes: Tasks start and end just after a rising edge
// Notes: Random windows from a fixed seed plus area boundaries
`timescale 1ns/1ns
`default_nettype none
module mbm_slave_map_test;
   typedef struct packed
   {
      logic err;
      logic [3:0] kind;
      logic [15:0] idx;
      logic up;
   } mbm_exp_t;
   logic ref_clk, reset_n, go, regWe;
   logic [7:0] goFunc, f;
   logic [15:0] goAddr, goQty, regIdx, regWdata;
   wire logic reqValid, respValid, respErr, respBadFunc, respUpper, respWrite, regHit, remapActive;
   wire logic [7:0] reqFunc;
   wire logic [15:0] reqAddr, reqQty, respIndex, regRdata;
   mbm_pkg::mbm_kind_t respKind;
   int err_count, n_checks, seed, i, k, r;
   logic [15:0] cfg [13];
   int arBase [16] = '{0, 1000, 2000, 3912, 6000, 9000, 9500, 0, 3840, 3904, 3968, 5000, 6000,
                       9000, 9500, 9700};
   int arCnt [16] = '{256, 256, 1912, 90, 1000, 256, 256, 3840, 64, 64, 200, 999, 2999, 256,
                      200, 112};
   int arIdx [16] = '{0, 0, 0, 1912, 0, 0, 0, 0, 3840, 3904, 3968, 5000, 0, 0, 0, 0};
   int arKind [16] = '{1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 15};
   logic [7:0] codes [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0f, 8'h10};
   logic [7:0] wCode [4] = '{8'h01, 8'h02, 8'h04, 8'h03};

   mbm_master_model u_mbm_master_model (.ref_clk, .go, .goFunc, .goAddr, .goQty, .reqValid,
      .reqFunc, .reqAddr, .reqQty);
   mbm_slave_map u_mbm_slave_map (.ref_clk, .reset_n, .reqValid, .reqFunc, .reqAddr, .reqQty,
      .respValid, .respErr, .respBadFunc, .respKind, .respIndex, .respUpper, .respWrite, .regWe,
      .regIdx, .regWdata, .regHit, .regRdata, .remapActive);

   initial
   begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   function automatic mbm_exp_t expect_map(logic [7:0] fc, logic [15:0] a, logic [15:0] q);
      mbm_exp_t e;
      int n, s, st, ln, ix;
      logic bitF;
      e = '{1'b1, 4'h0, 16'h0000, 1'b0};
      n = (fc == 8'h05 || fc == 8'h06) ? 1 : int'(q);
      bitF = fc inside {8'h01, 8'h02, 8'h05, 8'h0f};
      if (!(fc inside {codes}) || n == 0)
         return e;
      if (fc == 8'h02 || fc == 8'h04 || cfg[0] == 16'ha55a)
      begin
         s = fc == 8'h02 ? 4 : fc == 8'h04 ? 7 : bitF ? 1 : 10;
         st = cfg[s];
         ln = cfg[s + 2];
         ix = cfg[s + 1] + a - st;
         if (ln >= 1 && ln <= (bitF ? 2001 : 3840) && a >= st && a + n <= st + ln
             && ix + n - 1 <= (bitF ? 2001 : 3839))
            e = '{1'b0, !bitF ? 4'h8 : ix >= 1912 ? 4'h4 : 4'h3, ix[15:0], 1'b0};
         return e;
      end
      for (int j = bitF ? 0 : 7; j <= (bitF ? 6 : 15); j++)
         if (a >= arBase[j] && a + n <= arBase[j] + arCnt[j])
         begin
            ix = a - arBase[j];
            e = '{1'b0, 4'(arKind[j]), j == 15 ? 16'(200 + ix / 2) : 16'(arIdx[j] + ix),
                  j == 15 && ix[0]};
         end
      return e;
   endfunction

   task automatic chk_map(mbm_exp_t e, logic [7:0] fc);
      logic bad;
      bad = !(fc inside {codes});
      n_checks++;
      if (respValid !== 1'b1 || respErr !== (e.err | bad) || respBadFunc !== bad
          || respKind !== e.kind || respIndex !== e.idx || respUpper !== e.up
          || (!bad && !e.err && respWrite !== (fc inside {8'h05, 8'h06, 8'h0f, 8'h10})))
      begin
         err_count++;
         $display("BAD map %h expected %h seen %h", fc, e,
                  {respErr, respKind, respIndex, respUpper});
      end
   endtask

   task automatic chk_val(string name, logic [15:0] exp, logic [15:0] got);
      n_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic req(logic [7:0] fc, logic [15:0] a, logic [15:0] q);
      regWe = 1'b0;
      go = 1'b1;
      goFunc = fc;
      goAddr = a;
      goQty = q;
      @(posedge ref_clk);
      #1 go = 1'b0;
      @(posedge ref_clk);
      #1 chk_map(expect_map(fc, a, q), fc);
   endtask

   task automatic wr(logic [15:0] idx, logic [15:0] d);
      regWe = 1'b1;
      regIdx = idx;
      regWdata = d;
      if (idx >= 16'h0f80 && idx <= 16'h0f8c)
         cfg[idx - 16'h0f80] = d;
      @(posedge ref_clk);
      #1;
   endtask

   task automatic rd(logic [15:0] idx);
      logic hit;
      hit = idx >= 16'h0f80 && idx <= 16'h0f8c;
      regWe = 1'b0;
      regIdx = idx;
      @(posedge ref_clk);
      #1 chk_val("rdata", hit ? cfg[idx - 16'h0f80] : 16'h0000, regRdata);
      chk_val("hit", {15'h0000, hit}, {15'h0000, regHit});
      chk_val("remap", {15'h0000, cfg[0] == 16'ha55a}, {15'h0000, remapActive});
   endtask

   task automatic win_sweep();
      for (int w = 0; w < 4; w++)
      begin
         r = cfg[1 + 3 * w] + cfg[3 + 3 * w];
         req(wCode[w], cfg[1 + 3 * w] - 16'h0001, 16'h0001);
         req(wCode[w], cfg[1 + 3 * w], 16'h0001);
         req(wCode[w], 16'(r - 1), 16'h0001);
         req(wCode[w], 16'(r - 1), 16'h0002);
      end
   endtask

   task automatic close_out();
      if (err_count == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial
   begin
      #(50 * 40000);
      err_count++;
      close_out();
   end

   initial
   begin
      seed = 73;
      reset_n = 1'b0;
      go = 1'b0;
      goFunc = 8'h00;
      goAddr = 16'h0000;
      goQty = 16'h0000;
      regWe = 1'b0;
      regIdx = 16'h0000;
      regWdata = 16'h0000;
      foreach (cfg[j]) cfg[j] = 16'h0000;
      repeat (20) @(posedge ref_clk);
      #1 reset_n = 1'b1;
      @(posedge ref_clk);
      #1;
      for (k = 0; k < 14; k++)
         rd(16'h0f80 + 16'(k));
      wr(16'h0f8d, 16'h1234);
      rd(16'h0f8d);
      req(8'h02, 16'h0000, 16'h0001);
      req(8'h04, 16'h0000, 16'h0001);
      req(8'h07, 16'h0000, 16'h0001);
      req(8'h03, 16'h0000, 16'h0000);
      for (k = 0; k < 16; k++)
      begin
         f = codes[k % 3 == 0 ? (k < 7 ? 0 : 2) : k % 3 == 1 ? (k < 7 ? 4 : 5) : (k < 7 ? 6 : 7)];
         req(f, 16'(arBase[k] - 1), 16'h0001);
         req(f, 16'(arBase[k]), 16'h0001);
         req(f, 16'(arBase[k] + arCnt[k] - 1), 16'h0001);
         req(f, 16'(arBase[k] + arCnt[k] - 1), 16'h0002);
         req(f, 16'(arBase[k] + 1), 16'h0003);
      end
      foreach (cfg[j])
         wr(16'h0f80 + 16'(j), j == 0 ? 16'ha55a : 16'(j * 37));
      wr(16'h0f81, 16'h0000);
      wr(16'h0f82, 16'h076c);
      wr(16'h0f83, 16'h0014);
      rd(16'h0f83);
      win_sweep();
      req(8'h03, 16'h1388, 16'h0001);
      wr(16'h0f80, 16'ha55b);
      win_sweep();
      for (i = 0; i < 60; i++)
      begin
         wr(16'h0f80, ($random(seed) & 1) ? 16'ha55a : 16'h0000);
         for (k = 1; k < 13; k++)
         begin
            r = $unsigned($random(seed));
            wr(16'h0f80 + 16'(k), 16'(k % 3 == 1 ? r % 200 : k % 3 == 2 ? r % 4100 : r % 4000));
         end
         rd(16'h0f80 + 16'($unsigned($random(seed)) % 13));
         for (k = 0; k < 10; k++)
            req(codes[$unsigned($random(seed)) % 8], 16'($unsigned($random(seed))
                % (k % 2 ? 400 : 10000)), 16'($unsigned($random(seed)) % 6));
      end
      reset_n = 1'b0;
      repeat (2) @(posedge ref_clk);
      #1 reset_n = 1'b1;
      foreach (cfg[j]) cfg[j] = 16'h0000;
      @(posedge ref_clk);
      #1 rd(16'h0f80);
      req(8'h01, 16'h0000, 16'h0001);
      close_out();
   end
endmodule
`default_nettype wire
